// File: cpv_dev.sv
// Valve end of the process-data framer, plus its transmit frame FIFO.
// Assumes the link interface and user inputs share clk_in.
// Overview of operation
// RULE1 - Identifiers are 0x180/0x200 plus node number
// RULE2 - One transmit and one receive message
// RULE3 - Send every 96 ms only while operational
// RULE4 - No sync object needed either way
// RULE5 - Eight data bytes, unfilled bytes are 0xFF
// RULE6 - Use bytes one to four, ignore rest
// RULE7 - Controller sends commands at most every 5 ms
// RULE8 - Configurable 10 to 10000 ms reception timeout
// RULE9 - Bytes one-two: position demand, low first
// RULE10 - Byte three: active/historical diagnostic clear bits
// RULE11 - Byte four: run/stop command bits
// RULE12 - Receive mapping reports seventeen entries
// RULE13 - Measured then desired position, low first
// RULE14 - Byte five: temperature code 0x00-0xFA
// RULE15 - Transmit mapping reports twenty-seven entries
// RULE16 - Start command to us or all: operational
// RULE17 - Use demand only when source is bus
// RULE18 - Code 0x9C40 is exactly full travel
// RULE19 - Timeout, range or bus-off sets fault bit
// RULE20 - Ignore frames not carrying our receive identifier
`timescale 1ns/10ps

// ------------------------------------------------------------------
// Shift-register FIFO; head and flags straight from flip-flops
// ------------------------------------------------------------------
module cpv_fifo #(
  parameter int W = 8,
  parameter int D = 16
) (
  // Clock and reset
  input  wire  logic         clk_in,
  input  wire  logic         resetn_in,
  // Fill side
  input  wire  logic         in_valid_in,
  output logic               in_ready_out,
  input  wire  logic [W-1:0] in_data_in,
  // Drain side
  output logic               out_valid_out,
  input  wire  logic         out_ready_in,
  output logic [W-1:0]       out_data_out
);
  localparam int CW = $clog2(D + 1);

  typedef struct packed {
    logic [D-1:0][W-1:0] mem;
    logic [CW-1:0]       cnt;
    logic                valid;
    logic                full;
  } cpv_fifo_st_t;

  cpv_fifo_st_t r, n;
  logic         push, pop;

  // Shift on pop, write at first free slot
  always_comb begin
    n    = r;
    pop  = r.valid & out_ready_in;
    push = in_valid_in & ~r.full;
    if (pop) begin
      for (int i = 0; i < D - 1; i++) begin
        n.mem[i] = r.mem[i+1];
      end
    end
    n.cnt = r.cnt - CW'(pop);
    if (push) begin
      n.mem[n.cnt] = in_data_in;
    end
    n.cnt   = n.cnt + CW'(push);
    n.valid = (n.cnt != '0);
    n.full  = (n.cnt == CW'(D));
  end

  // State register
  always_ff @(posedge clk_in) begin
    if (!resetn_in) begin
      r <= '0;
    end else begin
      r <= n;
    end
  end

  assign in_ready_out  = ~r.full;
  assign out_valid_out = r.valid;
  assign out_data_out  = r.mem[0];
endmodule

// ------------------------------------------------------------------
// Valve end
// ------------------------------------------------------------------
module cpv_dev #(
  parameter int P_MS_CYC = cpv_pkg::MS_CYCLES
) (
  // Clock and reset
  input  wire  logic                 clk_in,
  input  wire  logic                 resetn_in,
  // Link
  cpv_link_if.dev                    link,
  // Configuration
  input  wire  logic [6:0]           node_id_in,
  input  wire  logic [13:0]          timeout_ms_in,
  input  wire  logic                 demand_can_in,
  input  wire  logic                 bus_off_in,
  // Valve data to send
  input  wire  logic [15:0]          act_pos_in,
  input  wire  logic [15:0]          des_pos_in,
  input  wire  logic [7:0]           temp_in,
  input  wire  logic [7:0]           stat1_in,
  input  wire  logic [7:0]           stat2_in,
  input  wire  logic [7:0]           stat3_in,
  // Decoded command
  output logic [15:0]                pos_dem_out,
  output logic                       pos_dem_stb_out,
  output logic [7:0]                 clr_bits_out,
  output logic [7:0]                 cmd_bits_out,
  // Status
  output cpv_pkg::cpv_nmt_t          nmt_state_out,
  output logic                       timeout_out,
  output logic                       range_err_out,
  output logic                       can_fault_out,
  output logic [7:0]                 rx_map_cnt_out,
  output logic [7:0]                 tx_map_cnt_out
);
  import cpv_pkg::*;

  typedef struct packed {
    cpv_nmt_t            nmt;
    logic [MS_CNT_W-1:0] ms_cnt;
    logic [6:0]          per_ms;
    logic [13:0]         to_ms;
    logic                timeout;
    logic                range_err;
    logic [15:0]         pos;
    logic                pos_stb;
    logic [7:0]          clr;
    logic [7:0]          cmd;
    logic                tx_pend;
    logic                rx_ready;
    logic                can_fault;
  } cpv_dev_st_t;

  cpv_dev_st_t r, n;
  cpv_frame_t  rx, tx;
  logic        tick, rx_take, tx_push, fifo_ready, valid_cmd;
  logic [13:0] lim;
  logic [10:0] tx_cob, rx_cob;

  // Identifiers from node number
  assign tx_cob = TX_COB_BASE + {4'h0, node_id_in}; // RULE1 RULE2
  assign rx_cob = RX_COB_BASE + {4'h0, node_id_in}; // RULE1 RULE2
  assign rx     = link.e2d_frame;

  // ----------------------------------------------------------------
  // Outgoing frame build
  // ----------------------------------------------------------------
  always_comb begin
    tx.id           = tx_cob;
    tx.dlc          = TX_DLC;                       // RULE5
    tx.data         = {8{FILL_BYTE}};               // RULE5
    tx.data[15:0]   = act_pos_in;                   // RULE13 RULE18
    tx.data[31:16]  = des_pos_in;                   // RULE13
    tx.data[39:32]  = (temp_in > TEMP_MAX) ? TEMP_MAX : temp_in; // RULE14
    tx.data[47:40]  = stat1_in;                     // RULE15
    tx.data[55:48]  = stat2_in;                     // RULE15
    tx.data[63:56]  = stat3_in;                     // RULE15
    tx.data[56+CAN_FAULT_BIT] = stat3_in[CAN_FAULT_BIT] | r.can_fault; // RULE19
  end

  // ----------------------------------------------------------------
  // Next-state logic
  // ----------------------------------------------------------------
  always_comb begin
    n          = r;
    n.pos_stb  = 1'b0;
    n.rx_ready = 1'b1;
    tick       = (r.ms_cnt == MS_CNT_W'(P_MS_CYC - 1));
    n.ms_cnt   = tick ? '0 : r.ms_cnt + 1'b1;
    lim        = (timeout_ms_in < TIMEOUT_MIN_MS) ? TIMEOUT_MIN_MS :
                 (timeout_ms_in > TIMEOUT_MAX_MS) ? TIMEOUT_MAX_MS : timeout_ms_in; // RULE8
    rx_take    = link.e2d_valid & r.rx_ready;      // RULE4
    valid_cmd  = 1'b0;
    tx_push    = 1'b0;

    // Network-management commands to us or to all
    if (rx_take && rx.id == NMT_COB && rx.dlc >= NMT_DLC &&
        (rx.data[15:8] == {1'b0, node_id_in} || rx.data[15:8] == NMT_ALL)) begin
      case (rx.data[7:0])
        NMT_START:   n.nmt = CPV_OPER;              // RULE16
        NMT_STOP:    n.nmt = CPV_STOPPED;
        NMT_PREOP:   n.nmt = CPV_PREOP;
        NMT_RST_APP: n.nmt = CPV_PREOP;
        NMT_RST_COM: n.nmt = CPV_PREOP;
        default:     n.nmt = r.nmt;
      endcase
    end

    // Command frame: own identifier only, first four bytes only
    if (rx_take && rx.id == rx_cob && rx.dlc >= RX_DLC_USED &&
        r.nmt == CPV_OPER) begin                    // RULE20 RULE4
      n.clr = rx.data[23:16];                       // RULE6 RULE10
      n.cmd = rx.data[31:24];                       // RULE6 RULE11
      if (rx.data[15:0] > POS_MAX) begin            // RULE9
        n.range_err = 1'b1;                         // RULE19
      end else begin
        n.range_err = 1'b0;
        valid_cmd   = 1'b1;
        if (demand_can_in) begin                    // RULE17
          n.pos     = rx.data[15:0];                // RULE9 RULE18
          n.pos_stb = 1'b1;
        end
      end
    end

    // Reception timeout supervision
    if (r.nmt == CPV_OPER && demand_can_in) begin
      if (valid_cmd) begin
        n.to_ms   = '0;
        n.timeout = 1'b0;
      end else if (tick) begin
        if (r.to_ms + 14'd1 >= lim) begin
          n.timeout = 1'b1;                         // RULE8
        end else begin
          n.to_ms = r.to_ms + 14'd1;
        end
      end
    end else begin
      n.to_ms   = '0;
      n.timeout = 1'b0;
    end

    // Periodic send; set of a new request wins over the push
    if (r.nmt == CPV_OPER) begin
      tx_push = r.tx_pend & fifo_ready;
      if (tx_push) begin
        n.tx_pend = 1'b0;
      end
      if (tick) begin
        if (r.per_ms == TX_PERIOD_MS - 7'd1) begin
          n.per_ms  = '0;
          n.tx_pend = 1'b1;                         // RULE3
        end else begin
          n.per_ms = r.per_ms + 7'd1;
        end
      end
    end else begin
      n.per_ms  = '0;
      n.tx_pend = 1'b0;                             // RULE3
    end

    n.can_fault = n.timeout | n.range_err | bus_off_in; // RULE19
  end

  // State register
  always_ff @(posedge clk_in) begin
    if (!resetn_in) begin
      r     <= '0;
      r.nmt <= CPV_PREOP;
    end else begin
      r <= n;
    end
  end

  // ----------------------------------------------------------------
  // Transmit FIFO towards the link
  // ----------------------------------------------------------------
  cpv_fifo #(
    .W (FRAME_W),
    .D (FIFO_DEPTH)
  ) u_txq (
    .clk_in        (clk_in),
    .resetn_in     (resetn_in),
    .in_valid_in   (tx_push),
    .in_ready_out  (fifo_ready),
    .in_data_in    (tx),
    .out_valid_out (link.d2e_valid),
    .out_ready_in  (link.d2e_ready),
    .out_data_out  (link.d2e_frame)
  );

  // Outputs from state register; map counts are constants
  assign link.e2d_ready  = r.rx_ready;
  assign pos_dem_out     = r.pos;
  assign pos_dem_stb_out = r.pos_stb;
  assign clr_bits_out    = r.clr;
  assign cmd_bits_out    = r.cmd;
  assign nmt_state_out   = r.nmt;
  assign timeout_out     = r.timeout;
  assign range_err_out   = r.range_err;
  assign can_fault_out   = r.can_fault;
  assign rx_map_cnt_out  = RX_MAP_ENTRIES;          // RULE12
  assign tx_map_cnt_out  = TX_MAP_ENTRIES;          // RULE15
endmodule

// File: cpv_pkg.sv
// Shared constants and types of the valve process-data message framer.
// Assumes one 50 MHz clock shared by both ends and the link between them.
package cpv_pkg;

  // ----------------------------------------------------------------
  // Timing
  // ----------------------------------------------------------------
  localparam int CLK_PERIOD_NS = 20;
  localparam int MS_NS         = 1000000;
  localparam int MS_CYCLES     = (MS_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int MS_CNT_W      = 26;
  localparam logic [6:0]  TX_PERIOD_MS   = 7'd96;
  localparam logic [2:0]  RX_MIN_GAP_MS  = 3'd5;
  localparam logic [13:0] TIMEOUT_MIN_MS = 14'd10;
  localparam logic [13:0] TIMEOUT_MAX_MS = 14'd10000;

  // ----------------------------------------------------------------
  // Identifiers and network-management codes
  // ----------------------------------------------------------------
  localparam logic [10:0] NMT_COB     = 11'h000;
  localparam logic [10:0] TX_COB_BASE = 11'h180;
  localparam logic [10:0] RX_COB_BASE = 11'h200;
  localparam logic [7:0]  NMT_START   = 8'h01;
  localparam logic [7:0]  NMT_STOP    = 8'h02;
  localparam logic [7:0]  NMT_PREOP   = 8'h80;
  localparam logic [7:0]  NMT_RST_APP = 8'h81;
  localparam logic [7:0]  NMT_RST_COM = 8'h82;
  localparam logic [7:0]  NMT_ALL     = 8'h00;
  localparam logic [3:0]  NMT_DLC     = 4'h2;

  // ----------------------------------------------------------------
  // Frame layout and scaling
  // ----------------------------------------------------------------
  localparam logic [3:0]  TX_DLC         = 4'h8;
  localparam logic [3:0]  RX_DLC_USED    = 4'h4;
  localparam logic [7:0]  FILL_BYTE      = 8'hFF;
  localparam logic [15:0] POS_MAX        = 16'hFAFF;
  localparam logic [15:0] POS_FULL_SCALE = 16'h9C40;
  localparam logic [7:0]  TEMP_MAX       = 8'hFA;
  localparam logic [7:0]  RX_MAP_ENTRIES = 8'd17;
  localparam logic [7:0]  TX_MAP_ENTRIES = 8'd27;
  localparam int          CAN_FAULT_BIT  = 4;
  localparam int          FRAME_W        = 79;
  localparam int          FIFO_DEPTH     = 16;

  // ----------------------------------------------------------------
  // Types
  // ----------------------------------------------------------------
  typedef enum logic [1:0] {CPV_PREOP, CPV_OPER, CPV_STOPPED} cpv_nmt_t;

  typedef struct packed {
    logic [10:0] id;
    logic [3:0]  dlc;
    logic [63:0] data;
  } cpv_frame_t;

endpackage

// File: cpv_link_if.sv
// Frame-level link between the valve end and the engine controller end.
// Assumes both ends run on the same clock; each direction is valid/ready.
`timescale 1ns/10ps
interface cpv_link_if;
  // Valve to controller
  logic                d2e_valid;
  logic                d2e_ready;
  cpv_pkg::cpv_frame_t d2e_frame;
  // Controller to valve
  logic                e2d_valid;
  logic                e2d_ready;
  cpv_pkg::cpv_frame_t e2d_frame;

  modport dev (output d2e_valid, input d2e_ready, output d2e_frame,
               input e2d_valid, output e2d_ready, input e2d_frame);
  modport ecu (input d2e_valid, output d2e_ready, input d2e_frame,
               output e2d_valid, input e2d_ready, output e2d_frame);
endinterface

// File: cpv_ecu.sv
// Engine controller end: builds start and command frames, unpacks valve data.
// Assumes the link interface and user inputs share clk_in.
`timescale 1ns/10ps
module cpv_ecu #(
  parameter int P_MS_CYC = cpv_pkg::MS_CYCLES
) (
  // Clock and reset
  input  wire  logic        clk_in,
  input  wire  logic        resetn_in,
  // Link
  cpv_link_if.ecu           link,
  // Requests
  input  wire  logic [6:0]  node_id_in,
  input  wire  logic        nmt_req_in,
  input  wire  logic [7:0]  nmt_cs_in,
  input  wire  logic [7:0]  nmt_node_in,
  input  wire  logic        cmd_req_in,
  input  wire  logic [15:0] pos_in,
  input  wire  logic [1:0]  clr_active_in,
  input  wire  logic [1:0]  clr_hist_in,
  input  wire  logic [1:0]  run_stop_in,
  input  wire  logic        accept_in,
  // Request status
  output logic              busy_out,
  output logic              cmd_ok_out,
  // Valve data received
  output logic              data_stb_out,
  output logic [15:0]       act_pos_out,
  output logic [15:0]       des_pos_out,
  output logic [7:0]        temp_out,
  output logic [7:0]        stat1_out,
  output logic [7:0]        stat2_out,
  output logic [7:0]        stat3_out,
  output logic              can_fault_out
);
  import cpv_pkg::*;

  typedef struct packed {
    logic                valid;
    cpv_frame_t          frm;
    logic [MS_CNT_W-1:0] ms_cnt;
    logic [2:0]          gap_ms;
    logic                gap_ok;
    logic                busy;
    logic                cmd_ok;
    logic                rdy;
    logic                stb;
    logic [63:0]         vd;
  } cpv_ecu_st_t;

  cpv_ecu_st_t r, n;
  logic        tick;
  logic [10:0] tx_cob;

  assign tx_cob = TX_COB_BASE + {4'h0, node_id_in};

  // ----------------------------------------------------------------
  // Next-state logic
  // ----------------------------------------------------------------
  always_comb begin
    n        = r;
    n.stb    = 1'b0;
    n.rdy    = accept_in;
    tick     = (r.ms_cnt == MS_CNT_W'(P_MS_CYC - 1));
    n.ms_cnt = tick ? '0 : r.ms_cnt + 1'b1;

    // Minimum command spacing
    if (!r.gap_ok && tick) begin
      if (r.gap_ms == RX_MIN_GAP_MS - 3'd1) begin
        n.gap_ok = 1'b1;                            // RULE7
      end else begin
        n.gap_ms = r.gap_ms + 3'd1;
      end
    end

    // Frame leaves when taken
    if (r.valid && link.e2d_ready) begin
      n.valid = 1'b0;
    end

    // Load a new frame, start/stop commands first
    if (!r.valid) begin
      if (nmt_req_in) begin
        n.valid         = 1'b1;
        n.frm.id        = NMT_COB;
        n.frm.dlc       = NMT_DLC;
        n.frm.data      = {{6{FILL_BYTE}}, nmt_node_in, nmt_cs_in}; // RULE16
      end else if (cmd_req_in && r.gap_ok) begin
        n.valid         = 1'b1;
        n.frm.id        = RX_COB_BASE + {4'h0, node_id_in};
        n.frm.dlc       = RX_DLC_USED;
        n.frm.data      = {8{FILL_BYTE}};
        n.frm.data[15:0] = (pos_in > POS_MAX) ? POS_MAX : pos_in; // RULE9 RULE18
        n.frm.data[23:16] = {4'h0, clr_hist_in, clr_active_in};   // RULE10
        n.frm.data[31:24] = {6'h00, run_stop_in};                 // RULE11
        n.gap_ok        = 1'b0;                     // RULE7
        n.gap_ms        = '0;
        n.ms_cnt        = '0;
      end
    end

    // Valve data, taken with no sync object
    if (link.d2e_valid && r.rdy && link.d2e_frame.id == tx_cob &&
        link.d2e_frame.dlc == TX_DLC) begin         // RULE4
      n.vd  = link.d2e_frame.data;
      n.stb = 1'b1;
    end

    n.busy   = n.valid;
    n.cmd_ok = n.gap_ok & ~n.valid;
  end

  // State register
  always_ff @(posedge clk_in) begin
    if (!resetn_in) begin
      r        <= '0;
      r.gap_ok <= 1'b1;
      r.cmd_ok <= 1'b1;
    end else begin
      r <= n;
    end
  end

  // Outputs from state register
  assign link.e2d_valid = r.valid;
  assign link.e2d_frame = r.frm;
  assign link.d2e_ready = r.rdy;
  assign busy_out       = r.busy;
  assign cmd_ok_out     = r.cmd_ok;
  assign data_stb_out   = r.stb;
  assign act_pos_out    = r.vd[15:0];
  assign des_pos_out    = r.vd[31:16];
  assign temp_out       = r.vd[39:32];
  assign stat1_out      = r.vd[47:40];
  assign stat2_out      = r.vd[55:48];
  assign stat3_out      = r.vd[63:56];
  assign can_fault_out  = r.vd[56+CAN_FAULT_BIT];
endmodule

// File: cpv_assertions.sv
// Concurrent checks on the link joining the valve end and the controller end.
// Assumes one clock and a synchronous active-low reset shared by both ends.
`timescale 1ns/10ps
module cpv_assertions #(
  parameter int P_MS_CYC = cpv_pkg::MS_CYCLES
) (
  // Clock, reset and node number
  input wire logic                clk_in,
  input wire logic                resetn_in,
  input wire logic [6:0]          node_id_in,
  // Valve to controller
  input wire logic                d2e_valid,
  input wire logic                d2e_ready,
  input wire cpv_pkg::cpv_frame_t d2e_frame,
  // Controller to valve
  input wire logic                e2d_valid,
  input wire logic                e2d_ready,
  input wire cpv_pkg::cpv_frame_t e2d_frame
);
  import cpv_pkg::*;
  localparam int GAP = int'(RX_MIN_GAP_MS) * P_MS_CYC;
  int   gap_r;
  logic cmd_take;

  // A command is any taken frame that is not network management
  assign cmd_take = e2d_valid && e2d_ready && (e2d_frame.id != NMT_COB);

  // Cycles since the last command, saturating at the minimum gap
  always_ff @(posedge clk_in) begin
    if (!resetn_in) begin
      gap_r <= GAP;
    end else if (cmd_take) begin
      gap_r <= 0;
    end else if (gap_r < GAP) begin
      gap_r <= gap_r + 1;
    end
  end

  default clocking cb @(posedge clk_in); endclocking
  default disable iff (!resetn_in);

  e2d_hold_a: assert property (e2d_valid && !e2d_ready |=> e2d_valid && $stable(e2d_frame))
    else $error("command frame changed before it was taken");
  d2e_hold_a: assert property (d2e_valid && !d2e_ready |=> d2e_valid && $stable(d2e_frame))
    else $error("valve frame changed before it was taken");
  rx_ready_a: assert property ($past(resetn_in) |-> e2d_ready)
    else $error("valve end not ready for commands");
  tx_id_a: assert property (d2e_valid |-> d2e_frame.id == TX_COB_BASE + {4'h0, node_id_in})
    else $error("valve frame identifier wrong");
  tx_len_a: assert property (d2e_valid |-> d2e_frame.dlc == TX_DLC)
    else $error("valve frame length not eight");
  tx_temp_a: assert property (d2e_valid |-> d2e_frame.data[39:32] <= TEMP_MAX)
    else $error("temperature code out of range");
  cmd_id_a: assert property (cmd_take |-> e2d_frame.id[10:7] == RX_COB_BASE[10:7])
    else $error("command identifier outside receive block");
  cmd_len_a: assert property (cmd_take |-> e2d_frame.dlc >= RX_DLC_USED)
    else $error("command frame too short");
  cmd_pos_a: assert property (cmd_take |-> e2d_frame.data[15:0] <= POS_MAX)
    else $error("position demand above full range");
  nmt_len_a: assert property (e2d_valid && e2d_frame.id == NMT_COB |-> e2d_frame.dlc >= NMT_DLC)
    else $error("network command too short");
  cmd_gap_a: assert property (cmd_take |-> gap_r >= GAP)
    else $error("commands closer than minimum gap");
endmodule

// File: canopen_pdo_valve_message_framer_tb_top.sv
// Self-checking bench: valve end and controller end joined by the link.
// Assumes both ends share one clock; shortened millisecond for run time.
`timescale 1ns/10ps
module canopen_pdo_valve_message_framer_tb_top;
  import cpv_pkg::*;
  localparam int PMS = 20;
  localparam int PER = int'(TX_PERIOD_MS) * PMS;
  logic        clk_in = 1'b0, resetn_in = 1'b0, dem_can = 1'b1, bus_off = 1'b0;
  logic [6:0]  node = 7'h0E, e_node = 7'h0E;
  logic [13:0] tmo_ms = 14'h3FFF;
  logic [15:0] act = 16'h0000, des = 16'h0000, pos = 16'h0000, pos_dem;
  logic [7:0]  temp = 8'h00, st1 = 8'h00, st2 = 8'h00, st3 = 8'h00, nmt_cs = 8'h00;
  logic [7:0]  nmt_node = 8'h00, clr_bits, cmd_bits, rx_map, tx_map, e_t, e_s1, e_s2, e_s3;
  logic        nmt_req = 1'b0, cmd_req = 1'b0, accept = 1'b1, chk_en = 1'b1;
  logic [1:0]  clr_a = 2'h0, clr_h = 2'h0, run_stop = 2'h0;
  logic        pos_stb, tmo_flag, range_err, d_fault, busy, cmd_ok, data_stb, e_fault;
  logic [15:0] e_act, e_des;
  cpv_nmt_t    nmt_state;
  int          n_errors = 0, n_compared = 0, n_frames = 0, i, k;
  int unsigned n_seed;
  time         t_prev = 0, t_last = 0;
  logic [7:0]  cs_tab[9] = '{NMT_START, NMT_START, NMT_STOP, NMT_PREOP, NMT_START,
                             NMT_RST_APP, NMT_START, NMT_RST_COM, NMT_START};
  int          nd_tab[9] = '{2, 1, 0, 1, 0, 1, 1, 1, 0};
  cpv_nmt_t    st_tab[9] = '{CPV_PREOP, CPV_OPER, CPV_STOPPED, CPV_PREOP, CPV_OPER,
                             CPV_PREOP, CPV_OPER, CPV_PREOP, CPV_OPER};
  logic [15:0] pos_tab[4] = '{16'h0000, 16'h9C40, 16'hFAFF, 16'hFFFF};

  // Free-running clock
  always #10 clk_in = ~clk_in;

  cpv_link_if link ();
  cpv_dev #(.P_MS_CYC(PMS)) cpv_dev_inst (.clk_in(clk_in), .resetn_in(resetn_in), .link(link),
    .node_id_in(node), .timeout_ms_in(tmo_ms), .demand_can_in(dem_can), .bus_off_in(bus_off),
    .act_pos_in(act), .des_pos_in(des), .temp_in(temp), .stat1_in(st1), .stat2_in(st2),
    .stat3_in(st3), .pos_dem_out(pos_dem), .pos_dem_stb_out(pos_stb), .clr_bits_out(clr_bits),
    .cmd_bits_out(cmd_bits), .nmt_state_out(nmt_state), .timeout_out(tmo_flag),
    .range_err_out(range_err), .can_fault_out(d_fault), .rx_map_cnt_out(rx_map),
    .tx_map_cnt_out(tx_map));
  cpv_ecu #(.P_MS_CYC(PMS)) cpv_ecu_inst (.clk_in(clk_in), .resetn_in(resetn_in), .link(link),
    .node_id_in(e_node), .nmt_req_in(nmt_req), .nmt_cs_in(nmt_cs), .nmt_node_in(nmt_node),
    .cmd_req_in(cmd_req), .pos_in(pos), .clr_active_in(clr_a), .clr_hist_in(clr_h),
    .run_stop_in(run_stop), .accept_in(accept), .busy_out(busy), .cmd_ok_out(cmd_ok),
    .data_stb_out(data_stb), .act_pos_out(e_act), .des_pos_out(e_des), .temp_out(e_t),
    .stat1_out(e_s1), .stat2_out(e_s2), .stat3_out(e_s3), .can_fault_out(e_fault));
  cpv_assertions #(.P_MS_CYC(PMS)) cpv_assertions_inst (.clk_in(clk_in), .resetn_in(resetn_in),
    .node_id_in(node), .d2e_valid(link.d2e_valid), .d2e_ready(link.d2e_ready),
    .d2e_frame(link.d2e_frame), .e2d_valid(link.e2d_valid), .e2d_ready(link.e2d_ready),
    .e2d_frame(link.e2d_frame));

  // Expected valve frame from the current valve inputs, no fault active
  function automatic logic [63:0] exp_data();
    logic [7:0] t;
    t = (temp > TEMP_MAX) ? TEMP_MAX : temp;
    return {st3, st2, st1, t, des, act};
  endfunction

  // Whole expected frame: identifier, length and payload
  function automatic cpv_frame_t exp_frame();
    return {TX_COB_BASE + {4'h0, node}, TX_DLC, exp_data()};
  endfunction

  task automatic check(input logic [79:0] got, input logic [79:0] exp);
    n_compared++;
    if (got !== exp) begin
      n_errors++;
      $display("ERROR t=%0t got=%0h exp=%0h", $time, got, exp);
    end
  endtask

  task automatic wrap_up();
    if (n_errors == 0 && n_compared > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask

  task automatic hang();
    n_errors++;
    $display("ERROR t=%0t got=%0h exp=%0h", $time, 0, 1);
    wrap_up();
  endtask

  // Frame on the wire and frame unpacked at the controller
  always @(negedge clk_in) begin
    if (resetn_in && chk_en && link.d2e_valid) check(link.d2e_frame, exp_frame());
    if (data_stb === 1'b1) begin
      n_frames++;
      t_prev = t_last;
      t_last = $time;
      if (chk_en) check({e_s3, e_s2, e_s1, e_t, e_des, e_act}, exp_data());
    end
  end

  task automatic send_nmt(input logic [7:0] cs, input int sel, input cpv_nmt_t st);
    nmt_req = 1'b1;
    nmt_cs = cs;
    nmt_node = (sel == 0) ? NMT_ALL : {1'b0, node} + 8'(sel - 1);
    @(negedge clk_in) nmt_req = 1'b0;
    repeat (3) @(negedge clk_in);
    check(nmt_state, st);
  endtask

  task automatic send_cmd(input logic [15:0] p, input logic [1:0] ca, ch, rs, input logic stb);
    int j;
    logic got;
    for (j = 0; j < 400 && cmd_ok !== 1'b1; j++) @(negedge clk_in);
    if (j == 400) hang();
    {cmd_req, pos, clr_a, clr_h, run_stop} = {1'b1, p, ca, ch, rs};
    @(negedge clk_in) cmd_req = 1'b0;
    got = 1'b0;
    for (j = 0; j < 6 && !got; j++) @(negedge clk_in) got = (pos_stb === 1'b1);
    check(got, stb);
    if (got && stb) check({pos_dem, clr_bits, cmd_bits, range_err, busy, cmd_ok},
      {(p > POS_MAX) ? POS_MAX : p, 4'h0, ch, ca, 6'h00, rs, 3'h0});
  endtask

  // Main sequence
  initial begin
    n_seed = $urandom(62341);
    {act, des, temp, st1, st2, st3} = {$urandom, $urandom};
    repeat (4) @(negedge clk_in);
    resetn_in = 1'b1;
    check({nmt_state, rx_map, tx_map, tmo_flag}, {CPV_PREOP, RX_MAP_ENTRIES, TX_MAP_ENTRIES, 1'b0});
    send_cmd(16'h1234, 2'h1, 2'h2, 2'h1, 1'b0);
    repeat (PER + 100) @(negedge clk_in);
    check(n_frames, 0);
    for (i = 0; i < 9; i++) send_nmt(cs_tab[i], nd_tab[i], st_tab[i]);
    for (i = 0; i < 10; i++) send_cmd((i < 4) ? pos_tab[i] : 16'($urandom % 16'hFB00),
      2'($urandom), 2'($urandom), 2'($urandom), 1'b1);
    e_node = node + 7'h01;
    send_cmd(16'h4000, 2'h3, 2'h3, 2'h3, 1'b0);
    e_node = node;
    dem_can = 1'b0;
    send_cmd(16'h2000, 2'h0, 2'h0, 2'h2, 1'b0);
    chk_en = 1'b0;
    bus_off = 1'b1;
    repeat (3) @(negedge clk_in);
    check(d_fault, 1'b1);
    bus_off = 1'b0;
    repeat (3) @(negedge clk_in);
    check(d_fault, 1'b0);
    chk_en = 1'b1;
    dem_can = 1'b1;
    repeat (2 * PER + 50) @(negedge clk_in);
    check(t_last - t_prev, PER * CLK_PERIOD_NS);
    k = n_frames;
    for (i = 0; i < 2 * PER && n_frames == k; i++) @(negedge clk_in);
    if (i == 2 * PER) hang();
    accept = 1'b0;
    k = n_frames;
    repeat (17 * PER + PER / 2) @(negedge clk_in);
    check({link.d2e_valid, n_frames - k}, {1'b1, 32'd0});
    accept = 1'b1;
    repeat (200) @(negedge clk_in);
    check(n_frames - k, 17);
    send_nmt(NMT_STOP, 1, CPV_STOPPED);
    k = n_frames;
    repeat (2 * PER + 100) @(negedge clk_in);
    check(n_frames - k, 0);
    chk_en = 1'b0;
    send_nmt(NMT_START, 0, CPV_OPER);
    tmo_ms = 14'd5;
    send_cmd(16'h9C40, 2'h0, 2'h0, 2'h1, 1'b1);
    repeat (8 * PMS) @(negedge clk_in);
    check(tmo_flag, 1'b0);
    repeat (4 * PMS) @(negedge clk_in);
    check({tmo_flag, d_fault}, 2'b11);
    repeat (PER + 50) @(negedge clk_in);
    check(e_fault, 1'b1);
    wrap_up();
  end
endmodule
